// ===== hdl/ifb_flag_bank.sv
// Purpose: Interrupt request flag bank for three groups, APB slave
// Assumes: All sources and the bus run on pclk; requests are active high
// Notes:   Two-cycle access phase; flags newly set by a source latch status bits that drive irq through a group mask
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps

module ifb_flag_bank
    import ifb_pkg::*;
#(
    parameter logic EDGE_MODE = 1'b1
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,

    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,

    // Group 1 sources
    input  wire logic        ext_irq_one_req,
    input  wire logic        pin_change_req,
    input  wire logic        comparator_req,
    input  wire logic        i2c_a_master_req,
    input  wire logic        i2c_a_slave_req,

    // Group 2 sources
    input  wire logic        parallel_port_req,
    input  wire logic        out_compare_h_req,
    input  wire logic        out_compare_g_req,
    input  wire logic        out_compare_f_req,
    input  wire logic        out_compare_e_req,
    input  wire logic        in_capture_f_req,
    input  wire logic        in_capture_e_req,
    input  wire logic        in_capture_d_req,
    input  wire logic        in_capture_c_req,
    input  wire logic        spi_b_event_req,
    input  wire logic        spi_b_fault_req,

    // Group 3 sources
    input  wire logic        calendar_clock_req,
    input  wire logic        ext_irq_four_req,
    input  wire logic        ext_irq_three_req,
    input  wire logic        i2c_b_master_req,
    input  wire logic        i2c_b_slave_req,

    // Flag words toward the vector logic
    output logic      [15:0] irq_flags_group1,
    output logic      [15:0] irq_flags_group2,
    output logic      [15:0] irq_flags_group3,

    // Interrupt
    output logic             irq
);

    typedef struct packed {
        ifb_phase_t  phase;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [2:0]  status;
        logic [2:0]  mask;
        logic        irq;
    } ifb_main_state_t;

    ifb_main_state_t st_reg;
    ifb_main_state_t st_next;

    // Address to register select
    function automatic ifb_sel_t decode(input logic [11:0] addr);
        case (addr)
            OFS_GROUP1:  decode = SEL_GROUP1;
            OFS_GROUP2:  decode = SEL_GROUP2;
            OFS_GROUP3:  decode = SEL_GROUP3;
            OFS_STATUS:  decode = SEL_STATUS;
            OFS_MASK:    decode = SEL_MASK;
            OFS_PENDING: decode = SEL_PENDING;
            default:     decode = SEL_NONE;
        endcase
    endfunction : decode

    // Any access to an unmapped word, and a write to a read-only word, is an error
    function automatic logic bad_access(input ifb_sel_t s, input logic wr);
        bad_access = (s == SEL_NONE) || (wr && (s == SEL_PENDING));
    endfunction : bad_access

    ifb_sel_t                  sel;
    logic                      commit;
    logic [15:0]               lane_mask;
    logic [2:0][15:0]          src_vec;
    logic [2:0][15:0]          set_vec;
    logic [2:0][15:0]          grp_q;
    logic [2:0]                grp_fresh;
    logic [2:0]                grp_pend;
    logic [2:0]                stat_clr;

    ifb_flag_if #(.W(GROUP_W)) fbus [NUM_GROUPS] ();

    assign sel       = decode(paddr);
    assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // The write lands on the edge where pready is seen high
    assign commit = (st_reg.phase == PH_RESP) && psel && penable && pwrite && !st_reg.pslverr;

    // Source routing into the flag words
    always_comb begin
        src_vec = '0;
        src_vec[0][EXT_IRQ_ONE_FLAG_BIT]    = ext_irq_one_req;
        src_vec[0][PIN_CHANGE_FLAG_BIT]     = pin_change_req;
        src_vec[0][COMPARATOR_FLAG_BIT]     = comparator_req;
        src_vec[0][I2C_A_MASTER_FLAG_BIT]   = i2c_a_master_req;
        src_vec[0][I2C_A_SLAVE_FLAG_BIT]    = i2c_a_slave_req;
        src_vec[1][PARALLEL_PORT_FLAG_BIT]  = parallel_port_req;
        src_vec[1][OUT_COMPARE_H_FLAG_BIT]  = out_compare_h_req;
        src_vec[1][OUT_COMPARE_G_FLAG_BIT]  = out_compare_g_req;
        src_vec[1][OUT_COMPARE_F_FLAG_BIT]  = out_compare_f_req;
        src_vec[1][OUT_COMPARE_E_FLAG_BIT]  = out_compare_e_req;
        src_vec[1][IN_CAPTURE_F_FLAG_BIT]   = in_capture_f_req;
        src_vec[1][IN_CAPTURE_E_FLAG_BIT]   = in_capture_e_req;
        src_vec[1][IN_CAPTURE_D_FLAG_BIT]   = in_capture_d_req;
        src_vec[1][IN_CAPTURE_C_FLAG_BIT]   = in_capture_c_req;
        src_vec[1][SPI_B_EVENT_FLAG_BIT]    = spi_b_event_req;
        src_vec[1][SPI_B_FAULT_FLAG_BIT]    = spi_b_fault_req;
        src_vec[2][CALENDAR_CLOCK_FLAG_BIT] = calendar_clock_req;
        src_vec[2][EXT_IRQ_FOUR_FLAG_BIT]   = ext_irq_four_req;
        src_vec[2][EXT_IRQ_THREE_FLAG_BIT]  = ext_irq_three_req;
        src_vec[2][I2C_B_MASTER_FLAG_BIT]   = i2c_b_master_req;
        src_vec[2][I2C_B_SLAVE_FLAG_BIT]    = i2c_b_slave_req;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g++) begin : gen_group
            ifb_req_edge #(
                .W         (GROUP_W),
                .EDGE_MODE (EDGE_MODE)
            ) u_edge (
                .pclk    (pclk),
                .presetn (presetn),
                .req     (src_vec[g]),
                .set     (set_vec[g])
            );

            assign fbus[g].set   = set_vec[g];
            assign fbus[g].wr    = commit && (sel == ifb_sel_t'(g));
            assign fbus[g].wmask = lane_mask;
            assign fbus[g].wdata = pwdata[15:0];

            ifb_flag_reg #(
                .IMPL  (GROUP_IMPL[g]),
                .RESET (GROUP_RESET)
            ) u_flags (
                .pclk    (pclk),
                .presetn (presetn),
                .fb      (fbus[g])
            );

            assign grp_q[g]     = fbus[g].q;
            assign grp_fresh[g] = |fbus[g].fresh;
            assign grp_pend[g]  = |fbus[g].q;
        end
    endgenerate

    // Status bits cleared by writing ones in the low lane
    assign stat_clr = (commit && sel == SEL_STATUS && pstrb[0]) ? pwdata[2:0] : 3'h0;

    always_comb begin
        st_next = st_reg;

        case (st_reg.phase)
            PH_IDLE: begin
                // Wait one access cycle so read data come from a flop
                if (psel && penable) begin
                    st_next.phase   = PH_RESP;
                    st_next.pready  = 1'b1;
                    st_next.pslverr = bad_access(sel, pwrite);
                    st_next.prdata  = 32'h0000_0000;
                    if (!pwrite) begin
                        case (sel)
                            SEL_GROUP1:  st_next.prdata = {16'h0000, grp_q[0]};
                            SEL_GROUP2:  st_next.prdata = {16'h0000, grp_q[1]};
                            SEL_GROUP3:  st_next.prdata = {16'h0000, grp_q[2]};
                            SEL_STATUS:  st_next.prdata = {29'h0000_0000, st_reg.status};
                            SEL_MASK:    st_next.prdata = {29'h0000_0000, st_reg.mask};
                            SEL_PENDING: st_next.prdata = {29'h0000_0000, grp_pend};
                            default:     st_next.prdata = 32'h0000_0000;
                        endcase
                    end
                end
            end
            PH_RESP: begin
                st_next.phase   = PH_IDLE;
                st_next.pready  = 1'b0;
                st_next.pslverr = 1'b0;
                st_next.prdata  = 32'h0000_0000;
            end
            default: begin
                st_next.phase   = PH_IDLE;
                st_next.pready  = 1'b0;
                st_next.pslverr = 1'b0;
            end
        endcase

        if (commit && sel == SEL_MASK && pstrb[0]) begin
            st_next.mask = pwdata[2:0];
        end

        st_next.status = (st_reg.status & ~stat_clr) | grp_fresh;
        st_next.irq    = |(st_next.status & st_next.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{
                phase:   PH_IDLE,
                pready:  1'b0,
                pslverr: 1'b0,
                prdata:  32'h0000_0000,
                status:  STATUS_RESET,
                mask:    MASK_RESET,
                irq:     1'b0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata           = st_reg.prdata;
    assign pready           = st_reg.pready;
    assign pslverr          = st_reg.pslverr;
    assign irq              = st_reg.irq;
    assign irq_flags_group1 = grp_q[0];
    assign irq_flags_group2 = grp_q[1];
    assign irq_flags_group3 = grp_q[2];

endmodule : ifb_flag_bank

// ===== hdl/ifb_flag_if.sv
// Purpose: Carries write and set strobes to one flag group and its state back
// Assumes: Single pclk domain
// Notes:   ctrl side drives strobes, bank side holds the flags
`timescale 1ns/1ps
interface ifb_flag_if #(parameter int W = 16);
    logic         wr;
    logic [W-1:0] wmask;
    logic [W-1:0] wdata;
    logic [W-1:0] set;
    logic [W-1:0] q;
    logic [W-1:0] fresh;

    modport bank (input wr, wmask, wdata, set, output q, fresh);
    modport ctrl (output wr, wmask, wdata, set, input q, fresh);
endinterface : ifb_flag_if

// ===== hdl/ifb_flag_reg.sv
// Purpose: One group of sticky, software-writable interrupt flags
// Assumes: Strobes from ifb_flag_if are synchronous to pclk
// Notes:   Unimplemented bits are never stored and read as zero
`timescale 1ns/1ps
module ifb_flag_reg
    import ifb_pkg::*;
#(
    parameter logic [15:0] IMPL  = 16'hffff,
    parameter logic [15:0] RESET = GROUP_RESET
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Flag group
    ifb_flag_if.bank  fb
);
    typedef struct packed {
        logic [15:0] q;
    } ifb_flag_state_t;

    ifb_flag_state_t st_reg;
    ifb_flag_state_t st_next;
    logic [15:0]     written;

    always_comb begin
        st_next = st_reg;
        written = st_reg.q;
        if (fb.wr) begin
            written = (st_reg.q & ~fb.wmask) | (fb.wdata & fb.wmask);
        end
        st_next.q = (written | fb.set) & IMPL;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{q: RESET};
        end else begin
            st_reg <= st_next;
        end
    end

    assign fb.q     = st_reg.q & IMPL;
    assign fb.fresh = fb.set & ~st_reg.q & IMPL;
endmodule : ifb_flag_reg

// ===== hdl/ifb_pkg.sv
// Purpose: Constants and types shared by the interrupt flag bank files
// Assumes: 16-bit flag groups held in the low half of 32-bit APB words
// Notes:   Offsets, bit positions, masks and reset values live here only
package ifb_pkg;

    localparam int unsigned APB_ADDR_W = 12;
    localparam int unsigned GROUP_W    = 16;
    localparam int unsigned NUM_GROUPS = 3;

    // Byte offsets of the APB words
    localparam logic [11:0] OFS_GROUP1  = 12'h000;
    localparam logic [11:0] OFS_GROUP2  = 12'h004;
    localparam logic [11:0] OFS_GROUP3  = 12'h008;
    localparam logic [11:0] OFS_STATUS  = 12'h00c;
    localparam logic [11:0] OFS_MASK    = 12'h010;
    localparam logic [11:0] OFS_PENDING = 12'h014;

    // Group 1 bit positions
    localparam int EXT_IRQ_ONE_FLAG_BIT    = 4;
    localparam int PIN_CHANGE_FLAG_BIT     = 3;
    localparam int COMPARATOR_FLAG_BIT     = 2;
    localparam int I2C_A_MASTER_FLAG_BIT   = 1;
    localparam int I2C_A_SLAVE_FLAG_BIT    = 0;
    // Group 2 bit positions
    localparam int PARALLEL_PORT_FLAG_BIT  = 13;
    localparam int OUT_COMPARE_H_FLAG_BIT  = 12;
    localparam int OUT_COMPARE_G_FLAG_BIT  = 11;
    localparam int OUT_COMPARE_F_FLAG_BIT  = 10;
    localparam int OUT_COMPARE_E_FLAG_BIT  = 9;
    localparam int IN_CAPTURE_F_FLAG_BIT   = 8;
    localparam int IN_CAPTURE_E_FLAG_BIT   = 7;
    localparam int IN_CAPTURE_D_FLAG_BIT   = 6;
    localparam int IN_CAPTURE_C_FLAG_BIT   = 5;
    localparam int SPI_B_EVENT_FLAG_BIT    = 1;
    localparam int SPI_B_FAULT_FLAG_BIT    = 0;
    // Group 3 bit positions
    localparam int CALENDAR_CLOCK_FLAG_BIT = 14;
    localparam int EXT_IRQ_FOUR_FLAG_BIT   = 6;
    localparam int EXT_IRQ_THREE_FLAG_BIT  = 5;
    localparam int I2C_B_MASTER_FLAG_BIT   = 2;
    localparam int I2C_B_SLAVE_FLAG_BIT    = 1;

    // Implemented bits per group, index 0 is group 1
    localparam logic [2:0][15:0] GROUP_IMPL = {16'h4066, 16'h3fe3, 16'h001f};

    localparam logic [15:0] GROUP_RESET  = 16'h0000;
    localparam logic [2:0]  STATUS_RESET = 3'h0;
    localparam logic [2:0]  MASK_RESET   = 3'h0;

    typedef enum logic [2:0] {
        SEL_GROUP1  = 3'b000,
        SEL_GROUP2  = 3'b001,
        SEL_GROUP3  = 3'b010,
        SEL_STATUS  = 3'b011,
        SEL_MASK    = 3'b100,
        SEL_PENDING = 3'b101,
        SEL_NONE    = 3'b111
    } ifb_sel_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_RESP = 2'b01
    } ifb_phase_t;

endpackage : ifb_pkg

// ===== hdl/ifb_req_edge.sv
// Purpose: Turns peripheral request lines into set strobes, one cycle long in edge mode and level pass-through otherwise
// Assumes: Requests are synchronous to pclk
// Notes:   Edge mode keeps a held request from overriding a software clear
`timescale 1ns/1ps
module ifb_req_edge
    import ifb_pkg::*;
#(
    parameter int   W         = 16,
    parameter logic EDGE_MODE = 1'b1
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Requests in, strobes out
    input  wire logic [W-1:0] req,
    output logic      [W-1:0] set
);
    typedef struct packed {
        logic [W-1:0] req_q;
    } ifb_edge_state_t;

    ifb_edge_state_t st_reg;
    ifb_edge_state_t st_next;

    always_comb begin
        st_next       = st_reg;
        st_next.req_q = req;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign set = EDGE_MODE ? (req & ~st_reg.req_q) : req;
endmodule : ifb_req_edge

// ===== testbench/ifb_flag_bank_props.sv
// Purpose: Port-level checks on the interrupt flag bank
// Assumes: Single pclk domain, presetn async active low
// Notes:   Bound to every ifb_flag_bank instance
`timescale 1ns/1ps
module ifb_flag_bank_props
    import ifb_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // Sources and flags
    input wire logic        ext_irq_one_req,
    input wire logic        parallel_port_req,
    input wire logic        calendar_clock_req,
    input wire logic [15:0] irq_flags_group1,
    input wire logic [15:0] irq_flags_group2,
    input wire logic [15:0] irq_flags_group3
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic wr_done;
    assign wr_done = psel && penable && pready && pwrite;

    property p_g1_unimpl; (irq_flags_group1 & ~GROUP_IMPL[0]) == 16'h0000; endproperty
    a_g1_unimpl: assert property (p_g1_unimpl) else $error("group1 unused bit set");
    property p_g2_unimpl; (irq_flags_group2 & ~GROUP_IMPL[1]) == 16'h0000; endproperty
    a_g2_unimpl: assert property (p_g2_unimpl) else $error("group2 unused bit set");
    property p_g3_unimpl; (irq_flags_group3 & ~GROUP_IMPL[2]) == 16'h0000; endproperty
    a_g3_unimpl: assert property (p_g3_unimpl) else $error("group3 unused bit set");
    property p_set_g1; $rose(ext_irq_one_req) |=> irq_flags_group1[4]; endproperty
    a_set_g1: assert property (p_set_g1) else $error("group1 bit 4 not set");
    property p_set_g2; $rose(parallel_port_req) |=> irq_flags_group2[13]; endproperty
    a_set_g2: assert property (p_set_g2) else $error("group2 bit 13 not set");
    property p_set_g3; $rose(calendar_clock_req) |=> irq_flags_group3[14]; endproperty
    a_set_g3: assert property (p_set_g3) else $error("group3 bit 14 not set");
    property p_sticky; !wr_done |=> (irq_flags_group2 & $past(irq_flags_group2)) == $past(irq_flags_group2); endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without write");
    property p_ready; (psel && penable && !pready) |=> pready ##1 !pready; endproperty
    a_ready: assert property (p_ready) else $error("access phase length wrong");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr outside pready");
    property p_rdata; !pready |-> prdata == 32'h0000_0000; endproperty
    a_rdata: assert property (p_rdata) else $error("prdata nonzero while idle");
endmodule : ifb_flag_bank_props

bind ifb_flag_bank ifb_flag_bank_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .ext_irq_one_req(ext_irq_one_req),
    .parallel_port_req(parallel_port_req), .calendar_clock_req(calendar_clock_req),
    .irq_flags_group1(irq_flags_group1), .irq_flags_group2(irq_flags_group2),
    .irq_flags_group3(irq_flags_group3)
);

// ===== testbench/ifb_flag_bank_test.sv
// Purpose: Self-checking bench for the interrupt flag bank
// Assumes: APB master tasks, source model for requests
// Notes:   Each scenario task judges its own results
`timescale 1ns/1ps
module ifb_flag_bank_test;
    import ifb_pkg::*;

    localparam int BITPOS [21] = '{0, 1, 2, 3, 4, 0, 1, 5, 6, 7, 8, 9, 10, 11, 12, 13, 1, 2, 5, 6, 14};

    logic        pclk;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  pstrb   = 4'hf;
    logic [15:0] lvl_flags_group1;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [20:0] req;
    logic [15:0] irq_flags_group1;
    logic [15:0] irq_flags_group2;
    logic [15:0] irq_flags_group3;
    int          n_fail     = 0;
    int          num_checks = 0;

    ifb_src_model u_src (.pclk(pclk), .req(req));

    ifb_flag_bank u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .i2c_a_slave_req(req[0]), .i2c_a_master_req(req[1]), .comparator_req(req[2]),
        .pin_change_req(req[3]), .ext_irq_one_req(req[4]), .spi_b_fault_req(req[5]),
        .spi_b_event_req(req[6]), .in_capture_c_req(req[7]), .in_capture_d_req(req[8]),
        .in_capture_e_req(req[9]), .in_capture_f_req(req[10]), .out_compare_e_req(req[11]),
        .out_compare_f_req(req[12]), .out_compare_g_req(req[13]), .out_compare_h_req(req[14]),
        .parallel_port_req(req[15]), .i2c_b_slave_req(req[16]), .i2c_b_master_req(req[17]),
        .ext_irq_three_req(req[18]), .ext_irq_four_req(req[19]), .calendar_clock_req(req[20]),
        .irq_flags_group1(irq_flags_group1), .irq_flags_group2(irq_flags_group2),
        .irq_flags_group3(irq_flags_group3), .irq(irq)
    );

    // Level mode twin: a held request keeps its flag set
    ifb_flag_bank #(.EDGE_MODE(1'b0)) u_dut_lvl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(), .pready(), .pslverr(),
        .i2c_a_slave_req(req[0]), .i2c_a_master_req(req[1]), .comparator_req(req[2]),
        .pin_change_req(req[3]), .ext_irq_one_req(req[4]), .spi_b_fault_req(req[5]),
        .spi_b_event_req(req[6]), .in_capture_c_req(req[7]), .in_capture_d_req(req[8]),
        .in_capture_e_req(req[9]), .in_capture_f_req(req[10]), .out_compare_e_req(req[11]),
        .out_compare_f_req(req[12]), .out_compare_g_req(req[13]), .out_compare_h_req(req[14]),
        .parallel_port_req(req[15]), .i2c_b_slave_req(req[16]), .i2c_b_master_req(req[17]),
        .ext_irq_three_req(req[18]), .ext_irq_four_req(req[19]), .calendar_clock_req(req[20]),
        .irq_flags_group1(lvl_flags_group1), .irq_flags_group2(), .irq_flags_group3(), .irq()
    );

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            check("pready", 32'h1, 32'h0);
            tally_and_finish();
        end
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] d;
        logic        e;
        apb(1'b0, a, 32'h0, d, e);
        check("prdata", exp, d);
        check("pslverr", 32'(exp_err), 32'(e));
    endtask : rd_chk

    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic exp_err);
        logic [31:0] d;
        logic        e;
        apb(1'b1, a, v, d, e);
        check("pslverr", 32'(exp_err), 32'(e));
    endtask : wr

    function automatic logic [15:0] fw(input int g);
        return (g == 0) ? irq_flags_group1 : (g == 1) ? irq_flags_group2 : irq_flags_group3;
    endfunction : fw

    task automatic t_reset();
        for (int g = 0; g < 3; g++) begin
            rd_chk(OFS_GROUP1 + 12'(4 * g), 32'h0, 1'b0);
        end
        rd_chk(OFS_STATUS, 32'h0, 1'b0);
        rd_chk(OFS_MASK, 32'h0, 1'b0);
        check("irq", 32'h0, 32'(irq));
    endtask : t_reset

    task automatic t_sources();
        int g;
        for (int i = 0; i < 21; i++) begin
            g = (i < 5) ? 0 : (i < 16) ? 1 : 2;
            u_src.pulse(i);
            @(negedge pclk);
            check("flag word", 32'(16'h1 << BITPOS[i]), 32'(fw(g)));
            rd_chk(OFS_GROUP1 + 12'(4 * g), 32'(16'h1 << BITPOS[i]), 1'b0);
            wr(OFS_GROUP1 + 12'(4 * g), 32'h0, 1'b0);
            rd_chk(OFS_GROUP1 + 12'(4 * g), 32'h0, 1'b0);
        end
        check("irq", 32'h0, 32'(irq));
    endtask : t_sources

    task automatic t_rw();
        for (int g = 0; g < 3; g++) begin
            wr(OFS_GROUP1 + 12'(4 * g), 32'hffff_ffff, 1'b0);
            rd_chk(OFS_GROUP1 + 12'(4 * g), 32'(GROUP_IMPL[g]), 1'b0);
            wr(OFS_GROUP1 + 12'(4 * g), 32'h0, 1'b0);
        end
        // Low lane strobe write of ones leaves the upper byte clear
        pstrb <= 4'h1;
        wr(OFS_GROUP2, 32'hffff, 1'b0);
        rd_chk(OFS_GROUP2, 32'(GROUP_IMPL[1] & 16'h00ff), 1'b0);
        wr(OFS_GROUP2, 32'h0, 1'b0);
        pstrb <= 4'hf;
    endtask : t_rw

    task automatic t_set_wins();
        wr(OFS_GROUP3, 32'hffff, 1'b0);
        fork
            wr(OFS_GROUP3, 32'h0, 1'b0);
            begin
                repeat (2) @(posedge pclk);
                u_src.pulse(20);
            end
        join
        rd_chk(OFS_GROUP3, 32'h4000, 1'b0);
        wr(OFS_GROUP3, 32'h0, 1'b0);
    endtask : t_set_wins

    task automatic t_irq();
        wr(OFS_STATUS, 32'h7, 1'b0);
        wr(OFS_MASK, 32'h1, 1'b0);
        u_src.pulse(4);
        @(negedge pclk);
        check("irq", 32'h1, 32'(irq));
        rd_chk(OFS_STATUS, 32'h1, 1'b0);
        rd_chk(OFS_PENDING, 32'h1, 1'b0);
        wr(OFS_STATUS, 32'h1, 1'b0);
        @(negedge pclk);
        check("irq", 32'h0, 32'(irq));
        wr(OFS_MASK, 32'h0, 1'b0);
        wr(OFS_GROUP1, 32'h0, 1'b0);
        u_src.pulse(4);
        @(negedge pclk);
        check("irq", 32'h0, 32'(irq));
        rd_chk(OFS_STATUS, 32'h1, 1'b0);
    endtask : t_irq

    task automatic t_errors();
        wr(OFS_GROUP1, 32'h0, 1'b0);
        rd_chk(12'h018, 32'h0, 1'b1);
        wr(12'h002, 32'h1f, 1'b1);
        wr(OFS_PENDING, 32'h7, 1'b1);
        rd_chk(OFS_GROUP1, 32'h0, 1'b0);
    endtask : t_errors

    task automatic t_level();
        u_src.hold(4, 1'b1);
        wr(OFS_GROUP1, 32'h0, 1'b0);
        @(negedge pclk);
        check("edge flags", 32'h0, 32'(irq_flags_group1));
        check("level flags", 32'h10, 32'(lvl_flags_group1));
        u_src.hold(4, 1'b0);
        wr(OFS_GROUP1, 32'h0, 1'b0);
        @(negedge pclk);
        check("level flags", 32'h0, 32'(lvl_flags_group1));
    endtask : t_level

    task automatic t_rst_mid();
        u_src.pulse(20);
        wr(OFS_MASK, 32'h7, 1'b0);
        @(negedge pclk);
        check("irq", 32'h1, 32'(irq));
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check("flags after reset", 32'h0, 32'(irq_flags_group3));
        check("irq after reset", 32'h0, 32'(irq));
        t_reset();
    endtask : t_rst_mid

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_sources();
        t_rw();
        t_set_wins();
        t_irq();
        t_errors();
        t_level();
        t_rst_mid();
        tally_and_finish();
    end
endmodule : ifb_flag_bank_test

// ===== testbench/ifb_src_model.sv
// Purpose: Behavioural peripheral request sources
// Assumes: Requests launched by the bench through pulse and hold
// Notes:   One-cycle active-high pulses, changed just after pclk
`timescale 1ns/1ps
module ifb_src_model (
    // Clock
    input  wire logic        pclk,
    // Group 1 in 4:0, group 2 in 15:5, group 3 in 20:16
    output logic      [20:0] req
);
    initial req = 21'h000000;

    task automatic pulse(input int idx);
        @(posedge pclk);
        req[idx] <= 1'b1;
        @(posedge pclk);
        req[idx] <= 1'b0;
    endtask : pulse

    // Level held until changed again
    task automatic hold(input int idx, input logic v);
        @(posedge pclk);
        req[idx] <= v;
    endtask : hold
endmodule : ifb_src_model
